// ### common/dram_timing_pkg.sv
// Constants shared by the DRAM-side command timing core.
// Assumes a single 40 MHz core clock; every picosecond figure is
// turned into whole core cycles here, least times rounded up.
package dram_timing_pkg;

  // ****************************************************************
  // Clock and interval figures
  // ****************************************************************
  localparam int T_CK_PS = 25000;
  localparam int ACT_TO_PRE_MIN_PS = 45000;
  localparam int READ_TO_PRE_PS = 7500;
  localparam int PRECHARGE_PERIOD_PS = 15000;
  localparam int ODT_ON_DELAY_CK = 2;
  localparam int ODT_OFF_DELAY_HALF_CK = 5;
  localparam int MIN_INTERNAL_CK = 2;

  localparam int ACT_TO_PRE_CYC_RAW = (ACT_TO_PRE_MIN_PS + T_CK_PS - 1) / T_CK_PS;
  localparam int ACT_TO_PRE_CYC = (ACT_TO_PRE_CYC_RAW < 1) ? 1 : ACT_TO_PRE_CYC_RAW;
  localparam int READ_TO_PRE_CYC_RAW = (READ_TO_PRE_PS + T_CK_PS - 1) / T_CK_PS;
  localparam int READ_TO_PRE_CYC =
    (READ_TO_PRE_CYC_RAW < MIN_INTERNAL_CK) ? MIN_INTERNAL_CK : READ_TO_PRE_CYC_RAW;
  localparam int PRECHARGE_CYC_RAW = (PRECHARGE_PERIOD_PS + T_CK_PS - 1) / T_CK_PS;
  localparam int PRECHARGE_CYC = (PRECHARGE_CYC_RAW < 1) ? 1 : PRECHARGE_CYC_RAW;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int CNT_W = 4;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam logic [2:0] WR_CLOCKS_RESET = 3'h2;

  // ****************************************************************
  // Command codes on cmd_code
  // ****************************************************************
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_ACTIVE = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_PRECHARGE = 3'h4;
  localparam logic [2:0] CMD_PRECHARGE_ALL = 3'h5;
  localparam logic [2:0] CMD_LOAD_MODE = 3'h6;
  localparam logic [2:0] CMD_REFRESH = 3'h7;

  // Per-bank state, one-hot
  typedef enum logic [3:0] {
    BANK_IDLE = 4'h1,
    BANK_OPEN = 4'h2,
    BANK_AUTOPRE = 4'h4,
    BANK_CLOSING = 4'h8
  } bank_state_e;

endpackage

// ### hdl/dram_cmd_timing.sv
// Device-side command timing: bank lockout for auto precharge,
// write recovery total, and on-die termination latencies.
// Assumes commands arrive already decoded, one per mclk, from logic on
// the same clock; the termination pin comes from outside and is synced.
//
// Overview of operation
// - Early auto precharge is held internally until activate-to-precharge minimum passes.
// - Auto-precharge write total is write-recovery clocks plus precharge clocks, rounded up.
// - Termination starts turning on two clocks after its input is registered high.
// - Termination starts turning off three clocks after its input is registered low, the whole edge after 2.5.
`timescale 1ns/100ps
module dram_cmd_timing (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [dram_timing_pkg::BANK_W-1:0] cmd_bank,
  input wire logic cmd_auto_pre,
  input wire logic [2:0] mode_wr_clocks,
  input wire logic odt_pin,
  output logic [dram_timing_pkg::NUM_BANKS-1:0] bank_open_q,
  output logic [dram_timing_pkg::NUM_BANKS-1:0] bank_busy_q,
  output logic int_prech_q,
  output logic [dram_timing_pkg::BANK_W-1:0] int_prech_bank_q,
  output logic [dram_timing_pkg::CNT_W-1:0] dal_clocks_q,
  output logic odt_term_q
);
  import dram_timing_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ACT_TO_PRE_CYC >= (1 << CNT_W) || PRECHARGE_CYC + 7 >= (1 << CNT_W)) begin : g_chk
    $error("Counter width too small for the timing figures");
  end

  // Lowest pending bank wins the shared internal precharge slot
  function automatic logic [BANK_W-1:0] lowest_set(input logic [NUM_BANKS-1:0] v);
    logic [BANK_W-1:0] idx;
    idx = '0;
    for (int i = NUM_BANKS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = BANK_W'(i);
      end
    end
    return idx;
  endfunction

  // ****************************************************************
  // Mode field: write-recovery clocks
  // ****************************************************************
  logic [2:0] wr_clocks_q;
  logic [2:0] wr_clocks_d;
  logic [CNT_W-1:0] dal_clocks_d;

  // Captured only on a mode load, so later writes see a stable value
  always_comb begin
    wr_clocks_d = wr_clocks_q;
    if (cmd_valid && cmd_code == CMD_LOAD_MODE) begin
      wr_clocks_d = (mode_wr_clocks < 3'(MIN_INTERNAL_CK)) ? 3'(MIN_INTERNAL_CK) : mode_wr_clocks;
    end
    dal_clocks_d = CNT_W'(wr_clocks_d) + CNT_W'(PRECHARGE_CYC);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_clocks_q <= WR_CLOCKS_RESET;
      dal_clocks_q <= '0;
    end else begin
      wr_clocks_q <= wr_clocks_d;
      dal_clocks_q <= dal_clocks_d;
    end
  end

  // ****************************************************************
  // Per-bank lockout and auto precharge
  // ****************************************************************
  logic [NUM_BANKS-1:0] pre_req;
  logic [NUM_BANKS-1:0] pre_grant;
  logic [BANK_W-1:0] grant_idx;
  logic int_prech_d;

  // One internal precharge per cycle; a loser waits until it is the lowest pending bank
  always_comb begin
    grant_idx = lowest_set(pre_req);
    pre_grant = '0;
    if (|pre_req) begin
      pre_grant[grant_idx] = 1'b1;
    end
    int_prech_d = |pre_req;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      int_prech_q <= 1'b0;
      int_prech_bank_q <= '0;
    end else begin
      int_prech_q <= int_prech_d;
      int_prech_bank_q <= grant_idx;
    end
  end

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    bank_state_e st_q;
    bank_state_e st_d;
    logic [CNT_W-1:0] ras_q;
    logic [CNT_W-1:0] ras_d;
    logic [CNT_W-1:0] wait_q;
    logic [CNT_W-1:0] wait_d;
    logic hit;
    logic all_pre;

    // Lockout count runs from activate; access delay runs from the access
    always_comb begin
      hit = cmd_valid && (cmd_bank == BANK_W'(b));
      all_pre = cmd_valid && (cmd_code == CMD_PRECHARGE_ALL);
      st_d = st_q;
      ras_d = (ras_q != '0) ? ras_q - 1'b1 : ras_q;
      wait_d = (wait_q != '0) ? wait_q - 1'b1 : wait_q;
      pre_req[b] = (st_q == BANK_AUTOPRE) && (wait_q == '0) && (ras_q == '0);
      case (st_q)
        BANK_IDLE: begin
          if (hit && cmd_code == CMD_ACTIVE) begin
            st_d = BANK_OPEN;
            ras_d = CNT_W'(ACT_TO_PRE_CYC - 1);
          end
        end
        BANK_OPEN: begin
          if (all_pre || (hit && cmd_code == CMD_PRECHARGE)) begin
            st_d = BANK_CLOSING;
            wait_d = CNT_W'(all_pre ? PRECHARGE_CYC : PRECHARGE_CYC - 1);
          end else if (hit && cmd_auto_pre && cmd_code == CMD_READ) begin
            st_d = BANK_AUTOPRE;
            wait_d = CNT_W'(READ_TO_PRE_CYC - 1);
          end else if (hit && cmd_auto_pre && cmd_code == CMD_WRITE) begin
            st_d = BANK_AUTOPRE;
            wait_d = CNT_W'(wr_clocks_q) - 1'b1;
          end
        end
        BANK_AUTOPRE: begin
          if (pre_grant[b]) begin
            st_d = BANK_CLOSING;
            wait_d = CNT_W'(PRECHARGE_CYC - 1);
          end
        end
        BANK_CLOSING: begin
          if (wait_q == '0) begin
            st_d = BANK_IDLE;
          end
        end
        default: begin
          st_d = BANK_IDLE;
        end
      endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        st_q <= BANK_IDLE;
        ras_q <= '0;
        wait_q <= '0;
        bank_open_q[b] <= 1'b0;
        bank_busy_q[b] <= 1'b0;
      end else begin
        st_q <= st_d;
        ras_q <= ras_d;
        wait_q <= wait_d;
        bank_open_q[b] <= (st_d == BANK_OPEN) || (st_d == BANK_AUTOPRE);
        bank_busy_q[b] <= (st_d == BANK_AUTOPRE) || (st_d == BANK_CLOSING);
      end
    end
  end

  // ****************************************************************
  // On-die termination latency
  // ****************************************************************
  logic odt_s1_q;
  logic odt_s2_q;
  logic [1:0] odt_hist_q;
  logic [1:0] odt_hist_d;
  logic odt_term_d;

  // Turn-off lands on the whole edge after the half clock, the nearest
  // point a single-edge design can mark
  always_comb begin
    odt_hist_d = {odt_hist_q[0], odt_s2_q};
    odt_term_d = odt_hist_q[0] | odt_hist_q[1];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      odt_s1_q <= 1'b0;
      odt_s2_q <= 1'b0;
      odt_hist_q <= '0;
      odt_term_q <= 1'b0;
    end else begin
      odt_s1_q <= odt_pin;
      odt_s2_q <= odt_s1_q;
      odt_hist_q <= odt_hist_d;
      odt_term_q <= odt_term_d;
    end
  end

endmodule // dram_cmd_timing

// ### testbench/dram_cmd_timing_assertions.sv
// Timing checker for the command core: lockout, recovery, termination.
// Assumes it is bound onto dram_cmd_timing with port names unchanged.
`timescale 1ns/100ps
module dram_cmd_timing_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [2:0] cmd_bank,
  input wire logic [2:0] mode_wr_clocks,
  input wire logic odt_pin,
  input wire logic int_prech_q,
  input wire logic [2:0] int_prech_bank_q,
  input wire logic [3:0] dal_clocks_q,
  input wire logic odt_term_q
);
  import dram_timing_pkg::*;
  // ********
  // Properties
  // ********
  // Pulse never lands on a bank activated one or two edges before
  property p_lockout;
    @(posedge mclk) disable iff (!arst_n)
    int_prech_q |-> !($past(cmd_valid) && $past(cmd_code) == CMD_ACTIVE
      && $past(cmd_bank) == int_prech_bank_q) && !($past(cmd_valid, 2)
      && $past(cmd_code, 2) == CMD_ACTIVE && $past(cmd_bank, 2) == int_prech_bank_q);
  endproperty
  a_lockout: assert property (p_lockout) else $error("precharge inside lockout");
  // Recovery total follows a lone mode load, clamp included
  property p_dal;
    @(posedge mclk) disable iff (!arst_n)
    (cmd_valid && cmd_code == CMD_LOAD_MODE) ##1 !(cmd_valid && cmd_code == CMD_LOAD_MODE)
    |=> dal_clocks_q == (($past(mode_wr_clocks, 2) < 3'h2) ? 4'h2
      : {1'b0, $past(mode_wr_clocks, 2)}) + 4'(PRECHARGE_CYC);
  endproperty
  a_dal: assert property (p_dal) else $error("recovery total wrong");
  property p_odt_on_early;
    @(posedge mclk) disable iff (!arst_n) $rose(odt_pin) && !odt_term_q |=> !odt_term_q [*3];
  endproperty
  a_odt_on_early: assert property (p_odt_on_early) else $error("termination on early");
  property p_odt_on_settle;
    @(posedge mclk) disable iff (!arst_n) odt_pin [*8] |-> odt_term_q;
  endproperty
  a_odt_on_settle: assert property (p_odt_on_settle) else $error("termination not on");
  // Off takes one edge longer than on, so it survives two samples
  property p_odt_off_late;
    @(posedge mclk) disable iff (!arst_n) $fell(odt_pin) && odt_term_q |=> odt_term_q [*2];
  endproperty
  a_odt_off_late: assert property (p_odt_off_late) else $error("termination off early");
  property p_odt_off_settle;
    @(posedge mclk) disable iff (!arst_n) !odt_pin [*8] |-> !odt_term_q;
  endproperty
  a_odt_off_settle: assert property (p_odt_off_settle) else $error("termination not off");
endmodule // dram_cmd_timing_chk
bind dram_cmd_timing dram_cmd_timing_chk u_chk (.*);

// ### testbench/ddr_ctl_model.sv
// Controller model: drives decoded commands and the termination pin.
// Assumes callers enter its tasks at a falling edge of mclk.
`timescale 1ns/100ps
module ddr_ctl_model (
  input wire logic mclk,
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic [2:0] cmd_bank,
  output logic cmd_auto_pre,
  output logic [2:0] mode_wr_clocks,
  output logic odt_pin
);
  import dram_timing_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    // No refresh, self refresh or power-down is ever driven, and the run stays
    // far shorter than the longest allowed gap between refreshes
    cmd_code = CMD_NOP;
    cmd_bank = 3'h0;
    cmd_auto_pre = 1'b0;
    mode_wr_clocks = 3'h2;
    odt_pin = 1'b0;
  end
  // Idle bank and auto-precharge fields are inverted so a stale command never looks held
  task automatic issue(input logic [2:0] code, input logic [2:0] bank, input logic ap,
                       input int gap);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_bank = bank;
    cmd_auto_pre = ap;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_code = CMD_NOP;
    cmd_bank = ~bank;
    cmd_auto_pre = ~ap;
    // At least one idle edge follows every command, plus one per count of gap, so short intervals hold
    repeat (gap) @(negedge mclk);
  endtask
  task automatic load_mode(input logic [2:0] wr);
    mode_wr_clocks = wr;
    issue(CMD_LOAD_MODE, 3'h0, 1'b0, MIN_INTERNAL_CK);
  endtask
  task automatic set_odt(input logic v);
    @(negedge mclk);
    odt_pin = v;
  endtask
endmodule // ddr_ctl_model

// ### testbench/test_dram_cmd_timing.sv
// Self-checking bench: controller model against the timing core.
// Assumes the package is compiled first and the checker is bound.
`timescale 1ns/100ps
module test_dram_cmd_timing;
  import dram_timing_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid, cmd_auto_pre, odt_pin, int_prech_q, odt_term_q;
  logic [2:0] cmd_code, cmd_bank, mode_wr_clocks, int_prech_bank_q;
  logic [7:0] bank_open_q, bank_busy_q;
  logic [3:0] dal_clocks_q;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int wr_m = 2;
  int t;
  int exp_v;
  int act_cyc [8];
  int exp_q [$];
  int lat [2];
  always #12.5 mclk = ~mclk;
  ddr_ctl_model ctl (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_bank(cmd_bank), .cmd_auto_pre(cmd_auto_pre), .mode_wr_clocks(mode_wr_clocks),
    .odt_pin(odt_pin));
  dram_cmd_timing dut (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_auto_pre(cmd_auto_pre),
    .mode_wr_clocks(mode_wr_clocks), .odt_pin(odt_pin), .bank_open_q(bank_open_q),
    .bank_busy_q(bank_busy_q), .int_prech_q(int_prech_q),
    .int_prech_bank_q(int_prech_bank_q), .dal_clocks_q(dal_clocks_q), .odt_term_q(odt_term_q));
  task automatic chk(input string what, input int exp, input logic [31:0] got);
    checks_done++;
    if (got !== 32'(exp)) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ********
  // Reference model: edge and bank of every internal precharge
  // ********
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (arst_n && cmd_valid && cmd_code == CMD_ACTIVE) act_cyc[cmd_bank] = cyc;
    if (arst_n && cmd_valid && cmd_code == CMD_LOAD_MODE) begin
      wr_m = mode_wr_clocks < 2 ? 2 : int'(mode_wr_clocks);
    end
    if (arst_n && cmd_valid && cmd_auto_pre
        && (cmd_code == CMD_READ || cmd_code == CMD_WRITE)) begin
      t = cyc + (cmd_code == CMD_READ ? READ_TO_PRE_CYC : wr_m);
      if (t < act_cyc[cmd_bank] + ACT_TO_PRE_CYC) t = act_cyc[cmd_bank] + ACT_TO_PRE_CYC;
      exp_q.push_back((t + 1) * 8 + int'(cmd_bank));
    end
    // Outputs are unknown before the first edge in reset, so look only once released
    if (arst_n && int_prech_q !== 1'b0) begin
      exp_v = exp_q.size() > 0 ? exp_q.pop_front() : -1;
      chk("prech", exp_v, {29'(cyc), int_prech_bank_q});
    end else if (exp_q.size() > 0 && exp_q[0] / 8 < cyc) begin
      chk("prech", exp_q.pop_front(), 32'h0);
    end
    // Ceiling far above the few hundred cycles the sequence needs
    if (cyc > 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  // Main sequence: reset, random auto-precharge accesses, termination
  initial begin
    int b, wr;
    void'($urandom(32'h36bf));
    repeat (3) @(posedge mclk);
    chk("rst", 0, {dal_clocks_q, bank_open_q, int_prech_q, odt_term_q});
    @(negedge mclk);
    arst_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk("dal", 2 + PRECHARGE_CYC, dal_clocks_q);
    for (int i = 0; i < 24; i++) begin
      b = $urandom % 8;
      wr = $urandom % 8;
      ctl.load_mode(3'(wr));
      chk("dal", (wr < 2 ? 2 : wr) + PRECHARGE_CYC, dal_clocks_q);
      ctl.issue(CMD_ACTIVE, 3'(b), 1'b0, $urandom % 3);
      chk("open", 1 << b, bank_open_q);
      ctl.issue(i[0] ? CMD_WRITE : CMD_READ, 3'(b), 1'b1, 12);
      chk("idle", 0, {bank_open_q, bank_busy_q});
    end
    for (int k = 0; k < 2; k++) begin
      ctl.set_odt(k == 0);
      lat[k] = 0;
      while (odt_term_q !== (k == 0) && lat[k] < 12) begin
        @(negedge mclk);
        lat[k]++;
      end
      repeat (10) @(negedge mclk);
    end
    // Two synchroniser flops come ahead of the turn-on delay
    chk("odt_on", 2 + ODT_ON_DELAY_CK, lat[0]);
    chk("odt_gap", (ODT_OFF_DELAY_HALF_CK + 1) / 2 - ODT_ON_DELAY_CK, 32'(lat[1] - lat[0]));
    chk("left", 0, 32'(exp_q.size()));
    print_verdict();
  end
endmodule // test_dram_cmd_timing
